// *** hdl/frx_rx_data_recovery.sv ***
// Function
// - Digital mode samples and filters data at 29 samples per bit.
// - Only filter and clock recovery use bit rate clock; analog needs none.
// - Clock recovery offers fast, slow and automatic modes.
// - Slow mode settles slowly but strongly rejects noise.
// - Automatic mode starts fast, goes slow after lock.
// - Recovered clock shifts received bits into the receive FIFO.
// - Analog mode passes data through slicer only, no FIFO or clock.
// - Signal strength flag high when strength exceeds programmed threshold.
// - Signal strength flag readable in the status word.
// - Quality detector counts spikes on unfiltered received data.
// - Quality flag high when an active transmitter is in band.
// - Host writes quality threshold; device applies it to spike decision.
// - After oscillator stop, exactly 192 more host clock pulses appear.
// - Amplifier gain chosen in four steps from 0 to -20 dB.
// - Frequency control corrects offset in discrete synthesizer steps.
// - Programmable setting selects crystal load capacitance.
// - FIFO mode bit routes bits to FIFO, else to pins.
//
// Purpose: Receive data filter, clock recovery, validity flags, clock tail.
// Assumes: I_SAMPLE_CLK ticks at 29 times the bit rate in digital mode.
// Notes:   Link side runs on I_SAMPLE_CLK; results cross to the core clock.
`timescale 1ns/1ps
module frx_rx_data_recovery (
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RESET_N,
    input  wire logic              I_SAMPLE_CLK,
    input  wire logic              I_SAMPLE_RESET_N,
    input  wire logic              I_RAW_DATA,
    input  wire logic              I_RC_FILTERED,
    input  wire logic [7:0]        I_RSSI_LEVEL,
    input  wire logic [3:0]        I_FREQ_ERROR,
    input  wire logic              I_AFC_ENABLE,
    input  wire frx_pkg::frx_cfg_t I_CFG,
    input  wire logic              I_OSC_ENABLE,
    input  wire logic              I_CLKOUT_ENABLE,
    output logic                   O_FIFO_BIT,
    output logic                   O_FIFO_BIT_VALID,
    output logic                   O_DATA_PIN,
    output logic                   O_DCLK_PIN,
    output frx_pkg::frx_status_t   O_STATUS,
    output logic [1:0]             O_LNA_GAIN_STEP,
    output logic [3:0]             O_XTAL_LOAD,
    output logic [2:0]             O_AFC_STEP,
    output logic                   O_HOST_CLK
);
    // Link domain: sampling, digital filter, clock recovery.
    // A level is taken only once the last two sync stages agree.
    logic [2:0] raw_sync;
    logic       raw_s;
    always_ff @(posedge I_SAMPLE_CLK) begin
        if (!I_SAMPLE_RESET_N) begin
            raw_sync <= 3'h0;
            raw_s    <= 1'b0;
        end else begin
            raw_sync <= {raw_sync[1:0], I_RAW_DATA};
            if (raw_sync[2] == raw_sync[1]) begin
                raw_s <= raw_sync[2];
            end
        end
    end

    // Majority filter over the last samples of the 29x bit clock.
    logic [frx_pkg::FILT_TAPS-1:0] taps;
    logic [2:0]                    ones;
    logic                          filt;
    always_ff @(posedge I_SAMPLE_CLK) begin
        if (!I_SAMPLE_RESET_N) begin
            taps <= '0;
        end else begin
            taps <= {taps[frx_pkg::FILT_TAPS-2:0], raw_s};
        end
    end
    always_comb begin
        ones = 3'h0;
        for (int k = 0; k < frx_pkg::FILT_TAPS; k++) begin
            ones = ones + {2'h0, taps[k]};
        end
        filt = (ones >= frx_pkg::FILT_HI);
    end

    // Clock recovery: phase accumulator of 29 steps per bit.
    logic [5:0] phase;
    logic [5:0] next_phase;
    logic       filt_d;
    logic       cr_slow;
    logic [4:0] lock_cnt;
    logic       locked;
    logic       bit_tick;
    logic [5:0] step;
    always_comb begin
        step = cr_slow ? frx_pkg::SLOW_STEP : frx_pkg::FAST_STEP;
        next_phase = phase + 6'h01;
        bit_tick = 1'b0;
        if (phase == 6'(frx_pkg::FILT_RATIO - 1)) begin
            next_phase = 6'h00;
        end
        if (filt != filt_d) begin
            // Nudge phase toward the bit edge by the mode's step.
            if (phase < frx_pkg::PHASE_MID) begin
                next_phase = (phase > step) ? phase - step : 6'h00;
            end else if (phase + step < 6'(frx_pkg::FILT_RATIO)) begin
                next_phase = phase + step;
            end else begin
                next_phase = 6'h00;
            end
        end
        if (phase == frx_pkg::PHASE_MID) begin
            bit_tick = 1'b1;
        end
    end

    always_ff @(posedge I_SAMPLE_CLK) begin
        if (!I_SAMPLE_RESET_N) begin
            phase  <= 6'h00;
            filt_d <= 1'b0;
        end else if (I_CFG.digital_mode) begin
            phase  <= next_phase;
            filt_d <= filt;
        end
    end

    // Lock counting drives the automatic mode.
    always_ff @(posedge I_SAMPLE_CLK) begin
        if (!I_SAMPLE_RESET_N) begin
            lock_cnt <= 5'h00;
            locked   <= 1'b0;
        end else if (filt != filt_d) begin
            if (phase <= frx_pkg::SLOW_STEP ||
                phase >= 6'(frx_pkg::FILT_RATIO) - frx_pkg::SLOW_STEP) begin
                if (lock_cnt == frx_pkg::LOCK_CNT) begin
                    locked <= 1'b1;
                end else begin
                    lock_cnt <= lock_cnt + 5'h01;
                end
            end else begin
                lock_cnt <= 5'h00;
                locked   <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (frx_pkg::frx_cr_mode_t'(I_CFG.cr_mode))
            frx_pkg::FRX_CR_FAST: cr_slow = 1'b0;
            frx_pkg::FRX_CR_SLOW: cr_slow = 1'b1;
            frx_pkg::FRX_CR_AUTO: cr_slow = locked;
            default:              cr_slow = 1'b0;
        endcase
    end

    // Recovered bit and toggle for the core domain.
    logic rec_bit;
    logic rec_tgl;
    always_ff @(posedge I_SAMPLE_CLK) begin
        if (!I_SAMPLE_RESET_N) begin
            rec_bit <= 1'b0;
            rec_tgl <= 1'b0;
        end else if (bit_tick && I_CFG.digital_mode) begin
            rec_bit <= filt;
            rec_tgl <= ~rec_tgl;
        end
    end

    // Core domain: receive the recovered bit events.
    logic [2:0] tgl_sync;
    logic [2:0] lock_sync;
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            tgl_sync  <= 3'h0;
            lock_sync <= 3'h0;
        end else begin
            tgl_sync  <= {tgl_sync[1:0], rec_tgl};
            lock_sync <= {lock_sync[1:0], locked};
        end
    end

    // The slicer input crosses on the core clock.
    // Analog mode therefore keeps working while the link clock is stopped.
    logic [2:0] rc_sync;
    logic       rc_s;
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            rc_sync <= 3'h0;
            rc_s    <= 1'b0;
        end else begin
            rc_sync <= {rc_sync[1:0], I_RC_FILTERED};
            if (rc_sync[2] == rc_sync[1]) begin
                rc_s <= rc_sync[2];
            end
        end
    end

    logic bit_event;
    logic dclk;
    assign bit_event = tgl_sync[2] ^ tgl_sync[1];

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            O_FIFO_BIT       <= 1'b0;
            O_FIFO_BIT_VALID <= 1'b0;
            O_DATA_PIN       <= 1'b0;
            dclk             <= 1'b0;
        end else begin
            O_FIFO_BIT_VALID <= 1'b0;
            if (!I_CFG.digital_mode) begin
                O_DATA_PIN <= rc_s;
                dclk       <= 1'b0;
            end else if (bit_event) begin
                if (I_CFG.rx_fifo_mode_enable) begin
                    O_FIFO_BIT       <= rec_bit;
                    O_FIFO_BIT_VALID <= 1'b1;
                end else begin
                    O_DATA_PIN <= rec_bit;
                    dclk       <= 1'b1;
                end
            end else begin
                dclk <= 1'b0;
            end
        end
    end
    assign O_DCLK_PIN = dclk;

    // Quality detector: spikes are raw edges counted per window.
    logic [2:0] raw_c;
    logic       raw_cd;
    logic [15:0] win_cnt;
    logic [7:0]  spikes;
    logic        dq_flag;
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            raw_c   <= 3'h0;
            raw_cd  <= 1'b0;
            win_cnt <= 16'h0000;
            spikes  <= 8'h00;
            dq_flag <= 1'b0;
        end else begin
            raw_c  <= {raw_c[1:0], I_RAW_DATA};
            // The held level follows only settled sync stages.
            if (raw_c[2] == raw_c[1]) begin
                raw_cd <= raw_c[2];
            end
            if (win_cnt == frx_pkg::DQ_WINDOW) begin
                win_cnt <= 16'h0000;
                spikes  <= 8'h00;
                // Few spikes means clean FSK in band.
                dq_flag <= (spikes <= {5'h00, I_CFG.dq_threshold});
            end else begin
                win_cnt <= win_cnt + 16'h0001;
                if (raw_c[2] == raw_c[1] && raw_c[2] != raw_cd &&
                    spikes != 8'hff) begin
                    spikes <= spikes + frx_pkg::CNT_W_ONE;
                end
            end
        end
    end

    // Signal strength, gain, crystal load and frequency control.
    // The error word is taken only when two stages hold the same value,
    // so a word caught mid-change never reaches the step output.
    logic       rssi_flag;
    logic [3:0] ferr_a;
    logic [3:0] ferr_b;
    logic [3:0] ferr_sync;
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            rssi_flag       <= 1'b0;
            O_LNA_GAIN_STEP <= frx_pkg::GAIN_RESET;
            O_XTAL_LOAD     <= frx_pkg::XTAL_LOAD_RESET;
            O_AFC_STEP      <= frx_pkg::AFC_STEP_RESET;
            ferr_a          <= 4'h0;
            ferr_b          <= 4'h0;
            ferr_sync       <= 4'h0;
        end else begin
            rssi_flag       <= (I_RSSI_LEVEL > I_CFG.rssi_threshold);
            O_LNA_GAIN_STEP <= I_CFG.lna_gain_step;
            O_XTAL_LOAD     <= I_CFG.xtal_load;
            ferr_a          <= I_FREQ_ERROR;
            ferr_b          <= ferr_a;
            ferr_sync       <= ferr_b;
            if (I_AFC_ENABLE && ferr_sync == ferr_b) begin
                O_AFC_STEP <= ferr_sync[3:1];
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            O_STATUS <= '0;
        end else begin
            O_STATUS.rssi_flag         <= rssi_flag;
            O_STATUS.data_quality_flag <= dq_flag;
            if (lock_sync[2] == lock_sync[1]) begin
                O_STATUS.cr_locked <= lock_sync[2];
            end
        end
    end

    // Host clock with a fixed tail after the oscillator stops.
    logic [7:0] tail_cnt;
    logic       osc_d;
    logic       host_clk;
    logic       running;
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            tail_cnt <= 8'h00;
            osc_d    <= 1'b0;
            host_clk <= 1'b0;
            running  <= 1'b0;
        end else begin
            osc_d <= I_OSC_ENABLE;
            if (I_OSC_ENABLE) begin
                running  <= 1'b1;
                tail_cnt <= 8'(frx_pkg::CLK_TAIL_PULSES);
                host_clk <= ~host_clk;
            end else if (osc_d) begin
                tail_cnt <= 8'(frx_pkg::CLK_TAIL_PULSES);
                host_clk <= ~host_clk;
            end else if (running) begin
                host_clk <= ~host_clk;
                if (host_clk) begin
                    if (tail_cnt == frx_pkg::CNT_W_ONE) begin
                        running <= 1'b0;
                    end
                    tail_cnt <= tail_cnt - frx_pkg::CNT_W_ONE;
                end
            end
        end
    end
    // The enable only gates the pin; the tail still runs to its end.
    assign O_HOST_CLK = host_clk & I_CLKOUT_ENABLE;
endmodule // frx_rx_data_recovery

// *** hdl/frx_pkg.sv ***
// Purpose: Shared constants and carriers for the FSK receive back-end.
// Assumes: Core clock 100 MHz, link clock from the demodulator side.
// Notes:   Numbers used by the design are named here, except zeros, counter steps and the 8'hff spike limit.
package frx_pkg;
    localparam int FILT_RATIO     = 29;
    localparam int CLK_TAIL_PULSES = 192;
    localparam int ANALOG_MAX_KBPS = 256;
    localparam int CORE_CLK_MHZ   = 100;
    localparam logic [7:0] CNT_W_ONE = 8'h01;
    localparam int FILT_TAPS      = 5;
    localparam logic [2:0] FILT_HI = 3'h3;
    localparam logic [5:0] FAST_STEP = 6'h08;
    localparam logic [5:0] SLOW_STEP = 6'h02;
    localparam logic [4:0] LOCK_CNT = 5'h08;
    localparam logic [5:0] PHASE_MID = 6'h0e;
    localparam logic [1:0] GAIN_RESET = 2'h0;
    localparam logic [3:0] XTAL_LOAD_RESET = 4'h8;
    localparam logic [2:0] DQ_THR_RESET = 3'h4;
    localparam logic [7:0] RSSI_THR_RESET = 8'h80;
    localparam logic [2:0] AFC_STEP_RESET = 3'h0;
    localparam logic [15:0] DQ_WINDOW = 16'h03e8;

    typedef enum logic [1:0] {
        FRX_CR_FAST = 2'b00,
        FRX_CR_SLOW = 2'b01,
        FRX_CR_AUTO = 2'b10
    } frx_cr_mode_t;

    typedef struct packed {
        logic [7:0]  rssi_threshold;
        logic [2:0]  dq_threshold;
        logic [1:0]  lna_gain_step;
        logic [3:0]  xtal_load;
        logic        digital_mode;
        logic        rx_fifo_mode_enable;
        logic [1:0]  cr_mode;
    } frx_cfg_t;

    typedef struct packed {
        logic        rssi_flag;
        logic        data_quality_flag;
        logic        cr_locked;
    } frx_status_t;
endpackage

// *** sim/frx_rx_data_recovery_properties.sv ***
// Purpose: Port checks for the FSK receive back-end.
// Assumes: Core clock domain only.
// Notes:   Bound to the design below the module.
`timescale 1ns/1ps
module frx_rx_props (
    input  wire logic                 I_CORE_CLK,
    input  wire logic                 I_RESET_N,
    input  wire frx_pkg::frx_cfg_t    I_CFG,
    input  wire logic [7:0]           I_RSSI_LEVEL,
    input  wire logic                 I_OSC_ENABLE,
    input  wire logic                 I_CLKOUT_ENABLE,
    input  wire logic                 O_FIFO_BIT_VALID,
    input  wire logic                 O_DCLK_PIN,
    input  wire frx_pkg::frx_status_t O_STATUS,
    input  wire logic [1:0]           O_LNA_GAIN_STEP,
    input  wire logic [3:0]           O_XTAL_LOAD,
    input  wire logic                 O_HOST_CLK
);
    logic [7:0] quiet;
    logic [8:0] tail;
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RESET_N);
    // Counts cycles with the configuration unchanged.
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N || !$stable(I_CFG))
            quiet <= 8'h00;
        else if (quiet != 8'hff)
            quiet <= quiet + 8'h01;
    end
    // Counts host clock rises after the oscillator stops.
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N || $fell(I_OSC_ENABLE))
            tail <= 9'h000;
        else if (!I_OSC_ENABLE && $rose(O_HOST_CLK))
            tail <= tail + 9'h001;
    end
    property p_valid_pulse;
        O_FIFO_BIT_VALID |=> !O_FIFO_BIT_VALID [*8];
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("valid pulse too long");
    property p_analog;
        quiet > 8'h0f && !I_CFG.digital_mode |-> !O_FIFO_BIT_VALID && !O_DCLK_PIN;
    endproperty
    a_analog: assert property (p_analog)
        else $error("strobe in analog mode");
    property p_route;
        quiet > 8'h0f |->
            (I_CFG.rx_fifo_mode_enable ? !O_DCLK_PIN : !O_FIFO_BIT_VALID);
    endproperty
    a_route: assert property (p_route)
        else $error("bit routed wrong");
    property p_rssi_hi;
        (I_RSSI_LEVEL > I_CFG.rssi_threshold) [*4] |-> O_STATUS.rssi_flag;
    endproperty
    a_rssi_hi: assert property (p_rssi_hi)
        else $error("strength flag low");
    property p_rssi_lo;
        (I_RSSI_LEVEL <= I_CFG.rssi_threshold) [*4] |-> !O_STATUS.rssi_flag;
    endproperty
    a_rssi_lo: assert property (p_rssi_lo)
        else $error("strength flag high");
    property p_gain;
        $stable(I_CFG.lna_gain_step) [*3] |->
            O_LNA_GAIN_STEP == I_CFG.lna_gain_step;
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain step wrong");
    property p_xtal;
        $stable(I_CFG.xtal_load) [*3] |-> O_XTAL_LOAD == I_CFG.xtal_load;
    endproperty
    a_xtal: assert property (p_xtal)
        else $error("load setting wrong");
    property p_tail;
        $fell(I_OSC_ENABLE) && I_CLKOUT_ENABLE |-> ##[400:420] tail == 9'h0c0;
    endproperty
    a_tail: assert property (p_tail)
        else $error("clock tail count wrong");
endmodule // frx_rx_props

bind frx_rx_data_recovery frx_rx_props i_props (
    .I_CORE_CLK, .I_RESET_N, .I_CFG, .I_RSSI_LEVEL, .I_OSC_ENABLE,
    .I_CLKOUT_ENABLE, .O_FIFO_BIT_VALID, .O_DCLK_PIN, .O_STATUS,
    .O_LNA_GAIN_STEP, .O_XTAL_LOAD, .O_HOST_CLK
);

// *** sim/frx_demod_model.sv ***
// Purpose: Demodulator side: link clock and received bit stream.
// Assumes: Link period 125 ns.
// Notes:   Link clock stands still while i_run is low.
`timescale 1ns/1ps
module frx_demod_model (
    input  wire logic i_run,
    input  wire logic i_noisy,
    output logic      o_link_clk,
    output logic      o_raw,
    output logic      o_bit
);
    int   tick = 0;
    logic phase = 1'b0;
    initial begin
        o_bit = 1'b0;
        o_raw = 1'b0;
    end
    // Data changes on the falling link edge, a new bit every 29 ticks.
    always begin
        #62.5;
        phase = ~phase;
        o_link_clk = phase & i_run;
        if (!phase) begin
            tick = (tick == 28) ? 0 : tick + 1;
            if (tick == 0)
                o_bit = 1'($urandom_range(1));
            o_raw = o_bit ^ (i_noisy && tick % 3 == 1);
        end
    end
endmodule // frx_demod_model

// *** sim/frx_rx_data_recovery_bench.sv ***
// Purpose: Self-checking bench for the FSK receive back-end.
// Assumes: Core period 10 ns, link period 125 ns, fixed seed.
// Notes:   Expected values are worked out here.
`timescale 1ns/1ps
module frx_rx_data_recovery_bench;
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                srst_n = 1'b0;
    logic                run = 1'b1;
    logic                noisy = 1'b0;
    logic                osc = 1'b1;
    logic                clkout = 1'b1;
    logic                prev;
    logic [7:0]          rssi = 8'h00;
    logic [3:0]          ferr = 4'h0;
    frx_pkg::frx_cfg_t   cfg = 21'h000000;
    frx_pkg::frx_status_t status;
    logic                link_clk, raw, mbit, fbit, fvalid, dpin, dclk, hclk;
    logic [1:0]          gain;
    logic [3:0]          xtal;
    logic [2:0]          afcs;
    int                  num_errors = 0;
    int                  cmp_count = 0;
    int                  n;
    always #5 clk = ~clk;
    frx_demod_model i_model (.i_run(run), .i_noisy(noisy),
        .o_link_clk(link_clk), .o_raw(raw), .o_bit(mbit));
    frx_rx_data_recovery i_dut (
        .I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_SAMPLE_CLK(link_clk),
        .I_SAMPLE_RESET_N(srst_n), .I_RAW_DATA(raw), .I_RC_FILTERED(mbit),
        .I_RSSI_LEVEL(rssi), .I_FREQ_ERROR(ferr), .I_AFC_ENABLE(1'b1),
        .I_CFG(cfg), .I_OSC_ENABLE(osc), .I_CLKOUT_ENABLE(clkout),
        .O_FIFO_BIT(fbit), .O_FIFO_BIT_VALID(fvalid), .O_DATA_PIN(dpin),
        .O_DCLK_PIN(dclk), .O_STATUS(status), .O_LNA_GAIN_STEP(gain),
        .O_XTAL_LOAD(xtal), .O_AFC_STEP(afcs), .O_HOST_CLK(hclk));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares=%0d errors=%0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask
    // Counts host clock rises over a number of cycles into n.
    task automatic count_rises(input int c);
        n = 0;
        prev = hclk;
        repeat (c) begin
            tick(1);
            n += int'(hclk && !prev);
            prev = hclk;
        end
    endtask
    // Waits for 36 recovered bits and compares the last 12 with the sent bit.
    task automatic rx_bits(input logic pin_mode);
        int w;
        for (int b = 0; b < 36; b++) begin
            w = 0;
            while (!(pin_mode ? dclk : fvalid) && w < 2000) begin
                tick(1);
                w++;
            end
            if (w == 2000) begin
                num_errors++;
                finish_test();
            end
            if (b > 23)
                check(pin_mode ? dpin : fbit, mbit);
            tick(1);
        end
    endtask
    initial begin
        n = $urandom(32'h8e6a);
        cfg.xtal_load = 4'h3;
        tick(8);
        check(xtal, frx_pkg::XTAL_LOAD_RESET);
        rst_n = 1'b1;
        tick(40);
        srst_n = 1'b1;
        for (int i = 0; i < 24; i++) begin
            rssi = 8'($urandom);
            cfg.rssi_threshold = (i < 2) ? rssi - 8'(i) : 8'($urandom);
            cfg.lna_gain_step = 2'(i);
            cfg.xtal_load = 4'($urandom);
            ferr = 4'($urandom);
            tick(6);
            check(status.rssi_flag, rssi > cfg.rssi_threshold);
            check(gain, cfg.lna_gain_step);
            check(xtal, cfg.xtal_load);
            check(afcs, ferr[3:1]);
        end
        cfg.digital_mode = 1'b1;
        cfg.rx_fifo_mode_enable = 1'b1;
        for (int m = 0; m < 4; m++) begin
            cfg.cr_mode = 2'(m);
            rx_bits(1'b0);
            check(status.cr_locked, 1'b1);
        end
        cfg.rx_fifo_mode_enable = 1'b0;
        rx_bits(1'b1);
        cfg.dq_threshold = 3'h7;
        tick(3000);
        check(status.data_quality_flag, 1'b1);
        noisy = 1'b1;
        cfg.dq_threshold = 3'($urandom);
        tick(3000);
        check(status.data_quality_flag, 1'b0);
        noisy = 1'b0;
        cfg.digital_mode = 1'b0;
        run = 1'b0;
        for (int b = 0; b < 12; b++) begin
            n = 0;
            while (i_model.tick != 14 && n < 400) begin
                tick(1);
                n++;
            end
            if (n == 400) begin
                num_errors++;
                finish_test();
            end
            check(dpin, mbit);
            tick(14);
        end
        run = 1'b1;
        osc = 1'b0;
        count_rises(500);
        check(16'(n), 16'h00c0);
        clkout = 1'b0;
        osc = 1'b1;
        count_rises(50);
        check(16'(n), 16'h0000);
        finish_test();
    end
endmodule // frx_rx_data_recovery_bench
